// ### design/muxed_bus_demux_bridge.sv
// Multiplexed to demultiplexed processor bus bridge, top level
// Summary of operation
// - Latch the address/data lines in the cycle start is sampled.
// - Float addresses after grant loss, once cycles and locks end.
// - transfer_in_progress is combinational from start, no register.
// - lock_end is combinational from start, hold, state and read/write.
// - Transitions that keep lock_end asserted change one state bit only.
// - transfer_in_progress pin is two-way; others meet clock setup.
// - transfer_in_progress asserts one gate delay after transfer_start.
// - transfer_in_progress negates after the acknowledge edge.
// - Address latch transparent only in low clock half of start cycle.
// - Between cycles the last latched address stays on the outputs.
// - lock_end asserts with start, negates after acknowledge edge.
// - Processor puts the address on shared pins in first cycle.
// - Processor may drive address right after the previous cycle.
// - No snooping: snoop inputs ignored, no snoop answers.
// - Address enable follows grant while idle, holds while bus busy.
// - Hold term keeps transfer_in_progress up until an acknowledge.
// - Locked non-burst read start tracks the lock; others data phase.
module muxed_bus_demux_bridge
  import bridge_pkg::*;
(
  input  wire logic       mclk_i,            // Bus clock, 25 MHz
  input  wire logic       reset_i,           // Sync reset, active high
  input  wire logic       transfer_start_i,  // Start of a bus cycle
  input  wire xfer_term_s term_i,            // Acknowledge pair
  input  wire xfer_attr_s attr_i,            // Cycle attributes
  input  wire logic       bus_grant_i,       // Bus grant
  input  wire logic       bus_busy_i,        // Bus busy
  input  wire logic [1:0] snoop_ctrl_i,      // Snoop control, ignored
  input  wire logic       tip_pin_i,         // Level on the tip pin
  output logic            transfer_in_progress_out_o, // Tip drive value
  output logic            transfer_in_progress_oe_o,  // Tip drive enable
  output logic            lock_end_o,        // Lock end drive value
  output logic            lock_end_oe_o,     // Lock end drive enable
  output logic            addr_latch_en_o,   // Address latch transparent
  output logic            addr_out_en_o,     // Address latch drive enable
  output logic            tip_seen_o         // Registered tip pin level
);

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  bridge_state_e state;
  bridge_state_e next_state;
  logic          hold;
  logic          burst;
  logic          aoe;
  logic          ts_go;
  logic          ack;
  logic          err;
  logic          burst_start;
  logic          data_phase;
  logic          tip_pin_meta;
  logic [1:0]    snoop_unused;

  function automatic logic is_addr_state(input bridge_state_e s);
    return s inside {ST_IDLE, ST_LRD2A, ST_LRD3A,
                     ST_LWR3A, ST_LWR2A, ST_LWR1A};
  endfunction

  assign ack          = term_i.ack;
  assign err          = term_i.error_ack;
  assign ts_go        = transfer_start_i & aoe;
  assign burst_start  = {attr_i.size, ~attr_i.burst_inhibit} == SIZE_BURST;
  assign snoop_unused = snoop_ctrl_i;

  // --------------------------------------------------------------
  // Address latch control
  // --------------------------------------------------------------
  addr_latch_ctrl u_latch (
    .mclk_i          (mclk_i),
    .reset_i         (reset_i),
    .ts_i            (transfer_start_i),
    .bus_grant_i     (bus_grant_i),
    .bus_busy_i      (bus_busy_i),
    .addr_phase_i    (is_addr_state(state)),
    .addr_out_en_o   (aoe),
    .addr_latch_en_o (addr_latch_en_o)
  );

  assign addr_out_en_o = aoe;

  // --------------------------------------------------------------
  // Hold term
  // --------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hold <= 1'b0;
    end else begin
      hold <= ts_go | (hold & ~ack & ~err);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      burst <= 1'b0;
    end else if (ts_go) begin
      burst <= attr_i.size == SIZE_LINE && !attr_i.burst_inhibit;
    end
  end

  // --------------------------------------------------------------
  // Cycle state machine
  // --------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Data phases step on the acknowledge pair the same way everywhere
  function automatic bridge_state_e data_step(
    input bridge_state_e cur, input bridge_state_e retry,
    input bridge_state_e done, input logic a, input logic e);
    bridge_state_e r;
    r = cur;
    if (a && e) begin
      r = retry;
    end else if (a) begin
      r = done;
    end else if (e) begin
      r = ST_IDLE;
    end
    return r;
  endfunction

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (!ts_go) begin
          next_state = ST_IDLE;
        end else if (attr_i.locked && !attr_i.write && !burst_start) begin
          next_state = ST_LRD1D;
        end else begin
          next_state = ST_CYCD;
        end
      end
      ST_LRD1D: next_state = data_step(state, ST_IDLE, ST_LRD2A, ack, err);
      ST_LRD2A: begin
        if (transfer_start_i) begin
          next_state = attr_i.write ? ST_LWR1D : ST_LRD2D;
        end
      end
      ST_LRD2D: next_state = data_step(state, ST_LRD2A, ST_LRD3A, ack, err);
      ST_LRD3A: begin
        if (transfer_start_i) begin
          next_state = attr_i.write ? ST_LWR2D : ST_LRD3D;
        end
      end
      ST_LRD3D: next_state = data_step(state, ST_LRD3A, ST_LWR3A, ack, err);
      ST_LWR3A: begin
        if (transfer_start_i) begin
          next_state = attr_i.write ? ST_LWR3D : ST_IDLE;
        end
      end
      ST_LWR3D: next_state = data_step(state, ST_LWR3A, ST_LWR2A, ack, err);
      ST_LWR2A: begin
        if (transfer_start_i) begin
          next_state = ST_LWR2D;
        end
      end
      ST_LWR2D: next_state = data_step(state, ST_LWR2A, ST_LWR1A, ack, err);
      ST_LWR1A: begin
        if (transfer_start_i) begin
          next_state = ST_LWR1D;
        end
      end
      ST_LWR1D: next_state = data_step(state, ST_LWR1A, ST_IDLE, ack, err);
      ST_CYCD: begin
        next_state = data_step(state, ST_IDLE,
                               burst ? ST_CYCD1 : ST_IDLE, ack, err);
      end
      ST_CYCD1: next_state = data_step(state, ST_IDLE, ST_CYCD2, ack, err);
      ST_CYCD2: next_state = data_step(state, ST_IDLE, ST_CYCD3, ack, err);
      ST_CYCD3: next_state = data_step(state, ST_IDLE, ST_IDLE, ack, err);
      default:  next_state = ST_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // Regenerated strobes
  // --------------------------------------------------------------
  // Deliberately combinational: a register stage would cost a whole
  // clock against the target's sampling edge.
  assign data_phase = (state[STATE_DATA_BIT] && state != ST_LWR1A)
                    || state inside {ST_CYCD, ST_CYCD1, ST_CYCD2, ST_CYCD3};

  assign transfer_in_progress_out_o = ~reset_i
    & (ts_go | hold | data_phase);
  assign transfer_in_progress_oe_o  = ~reset_i & aoe;

  assign lock_end_o = ~reset_i
    & ((state == ST_LRD2A && (hold || transfer_start_i) && attr_i.write)
     || (state == ST_LWR1A && (hold || transfer_start_i))
     || state == ST_LWR1D);
  assign lock_end_oe_o = ~reset_i & aoe;

  // --------------------------------------------------------------
  // Tip pin sampling
  // --------------------------------------------------------------
  // Another master may drive tip; its level is synchronised before use.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tip_pin_meta <= 1'b0;
      tip_seen_o   <= 1'b0;
    end else begin
      tip_pin_meta <= tip_pin_i;
      tip_seen_o   <= tip_pin_meta;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  property p_tip_with_start;
    transfer_start_i && aoe |-> transfer_in_progress_out_o;
  endproperty
  a_tip_with_start: assert property (p_tip_with_start)
    else $error("tip not asserted with transfer start");

  property p_tip_holds;
    transfer_start_i && aoe && !ack && !err
      |=> transfer_in_progress_out_o;
  endproperty
  a_tip_holds: assert property (p_tip_holds)
    else $error("tip dropped before acknowledge");

  property p_tip_drops;
    state == ST_CYCD && ack && !err && !burst
      |=> !transfer_in_progress_out_o || transfer_start_i;
  endproperty
  a_tip_drops: assert property (p_tip_drops)
    else $error("tip not negated after acknowledge");

  property p_lock_seq;
    state == ST_IDLE && ts_go && attr_i.locked && !attr_i.write
      && !burst_start |=> state == ST_LRD1D;
  endproperty
  a_lock_seq: assert property (p_lock_seq)
    else $error("locked read did not enter lock tracking");

  property p_plain_cycle;
    state == ST_IDLE && ts_go && !attr_i.locked |=> state == ST_CYCD;
  endproperty
  a_plain_cycle: assert property (p_plain_cycle)
    else $error("plain start did not enter data phase");

  property p_retry;
    state == ST_LRD2D && ack && err |=> state == ST_LRD2A;
  endproperty
  a_retry: assert property (p_retry)
    else $error("retry did not return to address phase");

  property p_error_idle;
    data_phase && !ack && err |=> state == ST_IDLE;
  endproperty
  a_error_idle: assert property (p_error_idle)
    else $error("bus error did not return to idle");

  property p_wait;
    data_phase && !ack && !err |=> $stable(state);
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait state changed state");

  property p_aoe_hold;
    !reset_i && bus_busy_i |=> $stable(aoe);
  endproperty
  a_aoe_hold: assert property (p_aoe_hold)
    else $error("address enable changed while bus busy");

  property p_aoe_follow;
    !reset_i && !bus_busy_i |=> aoe == $past(bus_grant_i);
  endproperty
  a_aoe_follow: assert property (p_aoe_follow)
    else $error("address enable did not follow grant");

  property p_lock_end_last;
    state == ST_LWR1D |-> lock_end_o;
  endproperty
  a_lock_end_last: assert property (p_lock_end_last)
    else $error("lock end missing in last locked write");

  property p_one_bit;
    state == ST_LWR1A && next_state == ST_LWR1D
      |-> $countones(state ^ next_state) == 1;
  endproperty
  a_one_bit: assert property (p_one_bit)
    else $error("steady transition flipped several state bits");

  c_locked_read: cover property (state == ST_LRD1D ##1 state == ST_LRD2A);
  c_burst: cover property (state == ST_CYCD1);
  c_lock_end: cover property (lock_end_o);
  c_retry: cover property (data_phase && ack && err);

endmodule

// ### design/bridge_pkg.sv
// Shared constants, state codes and carrier types of the bus bridge
package bridge_pkg;

  // --------------------------------------------------------------
  // Transfer size codes {size[1:0], burst_not_inhibited}
  // --------------------------------------------------------------
  localparam logic [2:0] SIZE_BURST   = 3'h7;
  localparam logic [1:0] SIZE_LINE    = 2'h3;

  // --------------------------------------------------------------
  // State codes
  // --------------------------------------------------------------
  // Codes are fixed: several transitions must flip a single bit so the
  // decoded strobes cannot glitch.
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h00,
    ST_LRD1D  = 5'h01,
    ST_LRD2A  = 5'h02,
    ST_LRD2D  = 5'h09,
    ST_LRD3A  = 5'h08,
    ST_LRD3D  = 5'h0B,
    ST_LWR3A  = 5'h18,
    ST_LWR3D  = 5'h11,
    ST_LWR2A  = 5'h10,
    ST_LWR2D  = 5'h05,
    ST_LWR1A  = 5'h07,
    ST_LWR1D  = 5'h03,
    ST_CYCD   = 5'h14,
    ST_CYCD1  = 5'h15,
    ST_CYCD2  = 5'h17,
    ST_CYCD3  = 5'h16
  } bridge_state_e;

  localparam int unsigned STATE_DATA_BIT = 0;

  // --------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------
  typedef struct packed {
    logic       write;          // High on a write cycle
    logic       locked;         // Locked transfer attribute
    logic [1:0] size;           // Transfer size
    logic       burst_inhibit;  // Target refuses bursting
  } xfer_attr_s;

  typedef struct packed {
    logic ack;                  // Transfer acknowledge
    logic error_ack;            // Transfer error acknowledge
  } xfer_term_s;

endpackage

// ### design/addr_latch_ctrl.sv
// Address latch enable and address output enable generation
module addr_latch_ctrl
  import bridge_pkg::*;
(
  input  wire logic mclk_i,          // Bus clock
  input  wire logic reset_i,         // Synchronous reset, active high
  input  wire logic ts_i,            // Transfer start
  input  wire logic bus_grant_i,     // Bus grant
  input  wire logic bus_busy_i,      // Bus busy
  input  wire logic addr_phase_i,    // State allows an address capture
  output logic      addr_out_en_o,   // Latched address drive enable
  output logic      addr_latch_en_o  // Latch transparent when high
);

  logic aoe;

  // --------------------------------------------------------------
  // Output enable follows grant only while the bus is idle
  // --------------------------------------------------------------
  // A lost grant waits for bus_busy to drop, so a cycle or a locked
  // sequence in flight always finishes with the address still driven.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      aoe <= 1'b0;
    end else if (!bus_busy_i) begin
      aoe <= bus_grant_i;
    end
  end

  assign addr_out_en_o = aoe;

  // Transparent only in the low half of the start cycle; holds otherwise
  // New address on the shared lines is caught in the start cycle only
  assign addr_latch_en_o = ts_i & aoe & ~mclk_i
                         & addr_phase_i;

endmodule

// ### test/target_model.sv
// Target board model answering bus cycles with acknowledges
module target_model
  import bridge_pkg::*;
(
  input  wire logic       mclk_i,   // Bus clock
  input  wire logic       ts_i,     // Transfer start on the bus
  input  wire logic [1:0] waits_i,  // Wait states before the answer
  input  wire logic [2:0] beats_i,  // Consecutive answered beats
  input  wire xfer_term_s mode_i,   // Termination code to give
  output xfer_term_s      term_o    // Acknowledge pair to the bridge
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] wait_cnt = 2'h0;
  logic [2:0] beat_cnt = 3'h0;

  initial term_o = '0;

  // ----------------------------------------------------------------
  // Answer sequencing
  // ----------------------------------------------------------------
  // Strobes looked at on rising edges only; no data lines are ever
  // driven, so nothing lingers between cycles.
  always @(posedge mclk_i) begin
    term_o <= '0;
    if (beat_cnt != 3'h0) begin
      term_o   <= mode_i;
      beat_cnt <= beat_cnt - 3'h1;
    end else if (wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
      if (wait_cnt == 2'h1) begin
        term_o   <= mode_i;
        beat_cnt <= beats_i - 3'h1;
      end
    end else if (ts_i) begin
      if (waits_i == 2'h0) begin
        term_o   <= mode_i;
        beat_cnt <= beats_i - 3'h1;
      end else begin
        wait_cnt <= waits_i;
      end
    end
  end
endmodule

// ### test/muxed_bus_demux_bridge_bench.sv
// Self-checking bench of the multiplexed bus bridge
module muxed_bus_demux_bridge_bench;
  import bridge_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk;
  logic       reset;
  logic       ts;
  xfer_term_s term;
  xfer_attr_s attr;
  logic       grant;
  logic       busy;
  logic [1:0] snoop;
  logic       ext_tip;
  wire        tip_pin;
  logic       tip_out;
  logic       tip_oe;
  logic       lke;
  logic       lke_oe;
  logic       ale;
  logic       aoe;
  logic       tip_seen;
  logic [1:0] waits;
  logic [2:0] beats;
  xfer_term_s mode;
  int         mismatches;
  int         n_checks;

  // Another master drives the tip wire whenever the bridge does not
  assign tip_pin = tip_oe ? tip_out : ext_tip;

  muxed_bus_demux_bridge dut (
    .mclk_i                     (mclk),
    .reset_i                    (reset),
    .transfer_start_i           (ts),
    .term_i                     (term),
    .attr_i                     (attr),
    .bus_grant_i                (grant),
    .bus_busy_i                 (busy),
    .snoop_ctrl_i               (snoop),
    .tip_pin_i                  (tip_pin),
    .transfer_in_progress_out_o (tip_out),
    .transfer_in_progress_oe_o  (tip_oe),
    .lock_end_o                 (lke),
    .lock_end_oe_o              (lke_oe),
    .addr_latch_en_o            (ale),
    .addr_out_en_o              (aoe),
    .tip_seen_o                 (tip_seen)
  );

  target_model target (
    .mclk_i  (mclk),
    .ts_i    (ts),
    .waits_i (waits),
    .beats_i (beats),
    .mode_i  (mode),
    .term_o  (term)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: output %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Start held high through reset must not leak onto the strobes
  task automatic t_reset();
    repeat (8) @(posedge mclk);
    #5 check(tip_out, 1'b0);
    check(lke, 1'b0);
    check(tip_oe, 1'b0);
    @(posedge mclk);
    reset <= 1'b0;
    ts    <= 1'b0;
    grant <= 1'b0;
  endtask

  task automatic t_grant();
    @(posedge mclk);
    ts      <= 1'b1;
    ext_tip <= 1'b1;
    #25 check(ale, 1'b0);
    check(tip_out, 1'b0);
    @(posedge mclk);
    ts    <= 1'b0;
    grant <= 1'b1;
    @(posedge mclk);
    #5 check(tip_seen, 1'b1);
    check(aoe, 1'b1);
    check(tip_oe, 1'b1);
    @(posedge mclk);
    busy    <= 1'b1;
    grant   <= 1'b0;
    ext_tip <= 1'b0;
    repeat (2) @(posedge mclk);
    #5 check(aoe, 1'b1);
    check(tip_seen, 1'b0);
    @(posedge mclk);
    busy <= 1'b0;
    @(posedge mclk);
    #5 check(aoe, 1'b0);
    @(posedge mclk);
    grant <= 1'b1;
    @(posedge mclk);
    #5 check(aoe, 1'b1);
    check(lke_oe, 1'b1);
  endtask

  // One cycle: tip must stand w+b cycles after the start clock
  task automatic t_cycle(input xfer_term_s m, input logic [1:0] w,
                         input logic [2:0] b, input xfer_attr_s a);
    @(posedge mclk);
    ts    <= 1'b1;
    attr  <= a;
    mode  <= m;
    waits <= w;
    beats <= b;
    snoop <= snoop + 2'h1;
    #5 check(tip_out, 1'b1);
    check(ale, 1'b0);
    check(lke, 1'b0);
    #20 check(ale, 1'b1);
    @(posedge mclk);
    ts <= 1'b0;
    repeat (w + b) begin
      #5 check(tip_out, 1'b1);
      check(ale, 1'b0);
      @(posedge mclk);
    end
    #5 check(tip_out, 1'b0);
    #20 check(ale, 1'b0);
  endtask

  // Locked read, a retried second read, then the closing write
  task automatic t_locked();
    @(posedge mclk);
    ts    <= 1'b1;
    attr  <= 5'h08;
    mode  <= 2'h2;
    waits <= 2'h0;
    beats <= 3'h1;
    #5 check(lke, 1'b0);
    @(posedge mclk);
    ts <= 1'b0;
    #5 check(tip_out, 1'b1);
    @(posedge mclk);
    #5 check(tip_out, 1'b0);
    check(lke, 1'b0);
    @(posedge mclk);
    ts   <= 1'b1;
    mode <= 2'h3;
    #5 check(lke, 1'b0);
    @(posedge mclk);
    ts <= 1'b0;
    #5 check(tip_out, 1'b1);
    @(posedge mclk);
    mode <= 2'h2;
    #5 check(tip_out, 1'b0);
    @(posedge mclk);
    ts   <= 1'b1;
    attr <= 5'h18;
    #5 check(lke, 1'b1);
    #20 check(ale, 1'b1);
    @(posedge mclk);
    ts <= 1'b0;
    #5 check(lke, 1'b1);
    check(tip_out, 1'b1);
    @(posedge mclk);
    #5 check(lke, 1'b0);
    check(tip_out, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    n_checks   = 0;
    reset      = 1'b1;
    ts         = 1'b1;
    attr       = '0;
    grant      = 1'b1;
    busy       = 1'b0;
    snoop      = 2'h0;
    ext_tip    = 1'b0;
    waits      = 2'h0;
    beats      = 3'h1;
    mode       = '0;
    t_reset();
    t_grant();
    t_cycle(2'h2, 2'h0, 3'h1, 5'h00);
    t_cycle(2'h1, 2'h2, 3'h1, 5'h10);
    t_cycle(2'h3, 2'h1, 3'h1, 5'h00);
    t_cycle(2'h2, 2'h0, 3'h4, 5'h06);
    t_cycle(2'h2, 2'h0, 3'h1, 5'h07);
    t_cycle(2'h2, 2'h0, 3'h4, 5'h0E);
    t_locked();
    end_of_test();
  end

  // Whole run is about 55 cycles; this is far beyond it
  initial begin
    #20us;
    mismatches++;
    end_of_test();
  end
endmodule
